/* design/sfr_map.vh */
// Address map, field layout, reset values and table constants of the security filter.
`ifndef SFR_MAP_VH
`define SFR_MAP_VH
`define SFR_NSI 2
`define SFR_NPT 6
`define SFR_AW 16
`define SFR_RGN_LO 12
`define SFR_RW 4
`define SFR_TW 3
`define SFR_CW 4
`define SFR_CNT_ZERO 4'h0
`define SFR_ONE_HOT 2'h1
`define SFR_OFS_REMAP 4'h0
`define SFR_OFS_SEC 4'h4
`define SFR_OFS_STAT 4'h8
`define SFR_BE_LOW 0
`define SFR_WD_RMP 7:0
`define SFR_WD_SEC 5:0
`define SFR_ST_SEC 5:0
`define SFR_ST_RMP 15:8
`define SFR_ST_BUSY 16
`define SFR_RMP_RST 8'h00
`define SFR_SEC_RST 6'h3f
`define SFR_RESP_OK 2'h0
`define SFR_RESP_DECERR 2'h3
`define SFR_SRC_IN 2'h0
`define SFR_SRC_SEC 2'h1
`define SFR_SRC_NS 2'h2
`define SFR_SI_SRC 4'h8
`define SFR_MD_SEC 2'h0
`define SFR_MD_NS 2'h1
`define SFR_MD_BOOT 2'h2
`define SFR_PT_MODE 12'h892
`define SFR_TGT_CFG 3'h6
`define SFR_TGT_NONE 3'h7
`define SFR_DMAP 48'hffff_ffd6_3409
`define SFR_E_EN 14
`define SFR_E_RGA 13:10
`define SFR_E_TGA 9:7
`define SFR_E_RGB 6:3
`define SFR_E_TGB 2:0
`define SFR_E_NONE 15'h0000
`define SFR_RM0_B0 15'h4000
`define SFR_RM0_B1 15'h4017
`define SFR_RM0_B2 15'h438f
`define SFR_RM1_B0 15'h6346
`define SFR_RM1_B1 15'h4fa7
`endif

/* design/sfr_top.v */
// Security filter and remap controller with Avalon-MM configuration access.
// Operation
// - Interface attribute from input, Secure or Non-secure tie.
// - Config registers accept Secure accesses only.
// - Always-Secure point refuses Non-secure traffic.
// - Always-Non-secure point passes all traffic.
// - Boot point has software-writable security bit.
// - Non-secure to Secure point ends decode error.
// - Each APB peripheral has its own check.
// - In-flight work checked with old setting.
// - Security update waits for idle, no lock.
// - Security settings propagate point by point.
// - Eight-bit remap control, one bit per state.
// - Lowest asserted remap bit wins.
// - Remap effects configured per slave interface.
// - Remap can alias, move, remove, add regions.
// - Remap reaches slave interfaces in sequence.
// - Old remap kept while pending or locked.
// - Write answer means remap applied everywhere.
// - All bits clear gives default map.
//
// Our own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "sfr_map.vh"
module sfr_top (
  input wire sys_clk_i,
  input wire srst_i,
  input wire [3:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  input wire cfg_ns_i,
  output wire [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  output wire [1:0] avs_response_o,
  input wire [1:0] si_valid_i,
  input wire [31:0] si_addr_i,
  input wire [1:0] si_ns_i,
  input wire [1:0] si_lock_i,
  input wire [1:0] si_dn_ready_i,
  output wire [1:0] si_ready_o,
  output wire [1:0] si_fwd_o,
  output wire [5:0] si_tgt_o,
  output wire [3:0] si_resp_o,
  output wire [1:0] si_err_o,
  input wire [5:0] pt_done_i,
  output wire [5:0] pt_sec_o
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_PROP = 2'h1;
  localparam [1:0] ST_ACK = 2'h2;
  localparam [3:0] SRC_ALL = `SFR_SI_SRC;
  localparam [11:0] MODE_ALL = `SFR_PT_MODE;
  localparam [47:0] DMAP = `SFR_DMAP;

  // Forces fixed-mode points to their configured value; only boot points follow software.
  function [5:0] sec_fix;
    input [5:0] v;
    integer k;
    reg [1:0] m;
    begin
      sec_fix = v;
      for (k = 0; k < `SFR_NPT; k = k + 1) begin
        m = MODE_ALL[2*k +: 2];
        if (m == `SFR_MD_SEC) begin
          sec_fix[k] = 1'b1;
        end else if (m == `SFR_MD_NS) begin
          sec_fix[k] = 1'b0;
        end else if (m == `SFR_MD_BOOT) begin
          sec_fix[k] = v[k];
        end
      end
    end
  endfunction

  // Reset values go through the same forcing as software writes.
  localparam [5:0] SEC_INIT = sec_fix(`SFR_SEC_RST);

  // One table entry per remap bit and interface; unused bits decode to nothing.
  function [14:0] rm_entry;
    input integer si;
    input integer b;
    begin
      rm_entry = `SFR_E_NONE;
      if (si == 0) begin
        case (b)
          0: rm_entry = `SFR_RM0_B0;
          1: rm_entry = `SFR_RM0_B1;
          2: rm_entry = `SFR_RM0_B2;
          default: rm_entry = `SFR_E_NONE;
        endcase
      end else begin
        case (b)
          0: rm_entry = `SFR_RM1_B0;
          1: rm_entry = `SFR_RM1_B1;
          default: rm_entry = `SFR_E_NONE;
        endcase
      end
    end
  endfunction

  // Walks from bit 7 down so a lower asserted bit overrides a higher one.
  function [2:0] decode;
    input integer si;
    input [3:0] rgn;
    input [7:0] rmp;
    integer b;
    reg [14:0] e;
    begin
      decode = DMAP[rgn*`SFR_TW +: `SFR_TW];
      for (b = 7; b >= 0; b = b - 1) begin
        e = rm_entry(si, b);
        if (rmp[b] && e[`SFR_E_EN]) begin
          if (e[`SFR_E_RGA] == rgn) begin
            decode = e[`SFR_E_TGA];
          end else if (e[`SFR_E_RGB] == rgn) begin
            decode = e[`SFR_E_TGB];
          end
        end
      end
    end
  endfunction

  // Both interfaces may hit one point in the same cycle, so the count can rise by two.
  function [1:0] hits;
    input integer k;
    input [5:0] tg;
    input [1:0] acc;
    integer i;
    begin
      hits = 2'h0;
      for (i = 0; i < `SFR_NSI; i = i + 1) begin
        if (acc[i] && tg[`SFR_TW*i +: `SFR_TW] == k[2:0]) begin
          hits = hits + `SFR_ONE_HOT;
        end
      end
    end
  endfunction

  // A tied-off interface ignores its attribute input, so a master cannot talk itself Secure.
  function si_attr;
    input [1:0] src;
    input ns_in;
    begin
      case (src)
        `SFR_SRC_IN: si_attr = ns_in;
        `SFR_SRC_SEC: si_attr = 1'b0;
        `SFR_SRC_NS: si_attr = 1'b1;
        default: si_attr = 1'b1;
      endcase
    end
  endfunction

  // Config space and unmapped holes carry no point bit, so they never index the vector.
  function pt_secure;
    input [2:0] tg;
    input [5:0] sec;
    integer p;
    begin
      pt_secure = 1'b0;
      for (p = 0; p < `SFR_NPT; p = p + 1) begin
        if (tg == p[2:0]) begin
          pt_secure = sec[p];
        end
      end
    end
  endfunction

  reg [1:0] st_q;
  reg [7:0] rmp_req_q;
  reg [5:0] sec_req_q;
  reg [31:0] rd_q;
  reg [1:0] rsp_q;
  reg [31:0] rd_d;
  reg [31:0] stat;
  wire [5:0] sec_app;
  wire [15:0] rmp_all;
  wire [5:0] tgt_all;
  wire [1:0] acc_all;
  wire [1:0] pend_all;
  wire [`SFR_NSI:0] rm_ok;
  wire [`SFR_NPT:0] sc_ok;
  wire any_pend;
  wire any_lock;
  wire upd_done;
  wire req;
  wire hit_rm;
  wire hit_sc;
  wire hit_st;
  wire mapped;
  wire be_low;
  wire wr_rm;
  wire wr_sc;
  wire deny;

  assign rm_ok[0] = 1'b1;
  assign sc_ok[0] = 1'b1;
  assign any_pend = |pend_all;
  // A lock on any interface freezes every security point, not only the one it targets.
  assign any_lock = |si_lock_i;
  // Busy until every interface and every point holds the requested values.
  assign upd_done = rm_ok[`SFR_NSI] & sc_ok[`SFR_NPT];
  assign pt_sec_o = sec_app;

  genvar i;
  genvar k;
  generate
    for (i = 0; i < `SFR_NSI; i = i + 1) begin : g_si
      localparam [1:0] SRC = SRC_ALL[2*i +: 2];
      reg [7:0] rmp_q;
      reg fwd_q;
      reg err_q;
      reg [2:0] tgt_q;
      reg [1:0] resp_q;
      wire ns;
      wire [2:0] tgt;
      wire blk;
      wire pend;
      wire hole;
      wire to_cfg;
      wire to_sec;

      assign ns = si_attr(SRC, si_ns_i[i]);
      assign tgt = decode(i, si_addr_i[`SFR_AW*i+`SFR_RGN_LO +: `SFR_RW], rmp_q);
      // A Non-secure request to config space or to a Secure point never leaves.
      assign hole = tgt == `SFR_TGT_NONE;
      assign to_cfg = ns & (tgt == `SFR_TGT_CFG);
      assign to_sec = ns & pt_secure(tgt, sec_app);
      assign blk = hole | to_cfg | to_sec;
      // A blocked request is answered at once, with no wait on the downstream side.
      assign si_ready_o[i] = si_valid_i[i] & (blk | si_dn_ready_i[i]);
      assign pend = si_valid_i[i] & ~si_ready_o[i];
      assign pend_all[i] = pend;
      assign acc_all[i] = si_ready_o[i] & ~blk;
      assign tgt_all[`SFR_TW*i +: `SFR_TW] = tgt;
      assign rmp_all[8*i +: 8] = rmp_q;
      // The match chain orders adoption, so a later interface never runs ahead of an earlier one.
      assign rm_ok[i+1] = rm_ok[i] & (rmp_q == rmp_req_q);
      assign si_fwd_o[i] = fwd_q;
      assign si_err_o[i] = err_q;
      assign si_tgt_o[`SFR_TW*i +: `SFR_TW] = tgt_q;
      assign si_resp_o[2*i +: 2] = resp_q;

      always @(posedge sys_clk_i) begin
        if (srst_i) begin
          rmp_q <= `SFR_RMP_RST;
          fwd_q <= 1'b0;
          err_q <= 1'b0;
          tgt_q <= `SFR_TGT_NONE;
          resp_q <= `SFR_RESP_OK;
        end else begin
          // Adopts only after the interface ahead of it in the chain.
          if (rm_ok[i] & ~pend & ~si_lock_i[i]) begin
            rmp_q <= rmp_req_q;
          end
          fwd_q <= si_ready_o[i] & ~blk;
          err_q <= si_ready_o[i] & blk;
          if (si_ready_o[i]) begin
            tgt_q <= tgt;
            resp_q <= blk ? `SFR_RESP_DECERR : `SFR_RESP_OK;
          end
        end
      end
    end

    for (k = 0; k < `SFR_NPT; k = k + 1) begin : g_pt
      reg app_q;
      reg [`SFR_CW-1:0] cnt_q;
      wire [1:0] inc;

      assign inc = hits(k, tgt_all, acc_all);
      assign sec_app[k] = app_q;
      assign sc_ok[k+1] = sc_ok[k] & (app_q == sec_req_q[k]);

      always @(posedge sys_clk_i) begin
        if (srst_i) begin
          app_q <= SEC_INIT[k];
          cnt_q <= `SFR_CNT_ZERO;
        end else begin
          // Work already in flight keeps the setting it was checked with.
          if (sc_ok[k] & (cnt_q == `SFR_CNT_ZERO) & ~any_pend & ~any_lock) begin
            app_q <= sec_req_q[k];
          end
          // No overflow guard: more than fifteen open transfers to one point would wrap.
          cnt_q <= cnt_q + {2'h0, inc} - {3'h0, pt_done_i[k]};
        end
      end
    end
  endgenerate

  assign req = avs_read_i | avs_write_i;
  assign hit_rm = avs_address_i == `SFR_OFS_REMAP;
  assign hit_sc = avs_address_i == `SFR_OFS_SEC;
  assign hit_st = avs_address_i == `SFR_OFS_STAT;
  assign mapped = hit_rm | hit_sc | hit_st;
  assign be_low = avs_byteenable_i[`SFR_BE_LOW];
  assign wr_rm = hit_rm & be_low;
  assign wr_sc = hit_sc & be_low;
  assign deny = cfg_ns_i | ~mapped;

  always @* begin
    stat = 32'h0000_0000;
    stat[`SFR_ST_SEC] = sec_app;
    // Only the last interface is shown; it is the last one in the chain to adopt.
    stat[`SFR_ST_RMP] = rmp_all[8*(`SFR_NSI-1) +: 8];
    stat[`SFR_ST_BUSY] = ~upd_done;
  end

  // Reads return the requested values; the status word shows the applied ones.
  always @* begin
    rd_d = 32'h0000_0000;
    if (hit_rm) begin
      rd_d[`SFR_WD_RMP] = rmp_req_q;
    end else if (hit_sc) begin
      rd_d[`SFR_WD_SEC] = sec_req_q;
    end else if (hit_st) begin
      rd_d = stat;
    end
  end

  // A remap or security write is answered only once every copy matches, so the response doubles as a fence.
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      st_q <= ST_IDLE;
      rmp_req_q <= `SFR_RMP_RST;
      sec_req_q <= SEC_INIT;
      rd_q <= 32'h0000_0000;
      rsp_q <= `SFR_RESP_OK;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (req) begin
            // A refused read answers zero, so nothing leaks past the filter.
            rd_q <= 32'h0000_0000;
            st_q <= ST_ACK;
            if (deny) begin
              rsp_q <= `SFR_RESP_DECERR;
            end else begin
              rsp_q <= `SFR_RESP_OK;
              if (avs_read_i) begin
                rd_q <= rd_d;
              end else if (wr_rm) begin
                rmp_req_q <= avs_writedata_i[`SFR_WD_RMP];
                st_q <= ST_PROP;
              end else if (wr_sc) begin
                sec_req_q <= sec_fix(avs_writedata_i[`SFR_WD_SEC]);
                st_q <= ST_PROP;
              end
            end
          end
        end
        ST_PROP: begin
          if (upd_done) begin
            st_q <= ST_ACK;
          end
        end
        ST_ACK: begin
          st_q <= ST_IDLE;
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign avs_waitrequest_o = st_q != ST_ACK;
  assign avs_readdata_o = rd_q;
  assign avs_response_o = rsp_q;

endmodule
`default_nettype wire

/* bench/sfr_asserts.sv */
// Port-level concurrent checks for the security filter and remap controller.
`timescale 1ns/100ps
`default_nettype none
module sfr_asserts (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic cfg_ns_i,
  input wire logic avs_waitrequest_o,
  input wire logic [1:0] avs_response_o,
  input wire logic [31:0] avs_readdata_o,
  input wire logic [1:0] si_valid_i,
  input wire logic [1:0] si_dn_ready_i,
  input wire logic [1:0] si_ready_o,
  input wire logic [1:0] si_fwd_o,
  input wire logic [1:0] si_err_o,
  input wire logic [3:0] si_resp_o,
  input wire logic [5:0] pt_sec_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  sequence ack_s;
    avs_waitrequest_o ##1 !avs_waitrequest_o;
  endsequence
  sequence hs0_s;
    si_valid_i[0] && si_ready_o[0];
  endsequence
  ns_cfg_resp_a:
    assert property ((avs_read_i || avs_write_i) && cfg_ns_i && !avs_waitrequest_o
      |-> avs_response_o == 2'h3) else $error("ns config access answered OK");
  ns_cfg_data_a:
    assert property (avs_read_i && cfg_ns_i && !avs_waitrequest_o
      |-> avs_readdata_o == 32'h0000_0000) else $error("ns config read returned data");
  read_ack_a:
    assert property ($rose(avs_read_i) |-> ack_s) else $error("read not answered in one cycle");
  hs_answer_a:
    assert property (hs0_s |=> si_fwd_o[0] != si_err_o[0]) else $error("handshake without outcome");
  no_hs_quiet_a:
    assert property (!(si_valid_i[0] && si_ready_o[0]) |=> !si_fwd_o[0] && !si_err_o[0])
      else $error("outcome pulse without handshake");
  ready_pass_a:
    assert property (si_valid_i[0] && si_dn_ready_i[0] |-> si_ready_o[0])
      else $error("ready withheld from free downstream");
  err_code_a:
    assert property (si_err_o[0] |-> si_resp_o[1:0] == 2'h3 && !si_fwd_o[0])
      else $error("error pulse with wrong response");
  fixed_modes_a:
    assert property (pt_sec_o[1] && pt_sec_o[4] && !pt_sec_o[2]) else $error("fixed point mode moved");
  one_point_a:
    assert property ($onehot0(pt_sec_o ^ $past(pt_sec_o))) else $error("points adopted together");
endmodule
`default_nettype wire

/* bench/sfr_far.sv */
// Far-side model: downstream slaves taking one forwarded transfer at a time per interface.
`timescale 1ns/100ps
`default_nettype none
module sfr_far #(
  parameter int DLY = 6
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic [1:0] fwd_i,
  input wire logic [5:0] tgt_i,
  output logic [1:0] dn_ready_o,
  output logic [5:0] done_o
);
  logic [3:0] cnt_q [2];
  logic [2:0] pt_q [2];
  // A busy slave stalls the next address, so the filter sees real back-pressure.
  always_ff @(posedge sys_clk_i) begin
    done_o <= 6'h00;
    for (int i = 0; i < 2; i++) begin
      if (srst_i) begin
        cnt_q[i] <= 4'h0;
      end else if (fwd_i[i] && tgt_i[i*3 +: 3] < 3'h6) begin
        cnt_q[i] <= 4'(DLY);
        pt_q[i] <= tgt_i[i*3 +: 3];
      end else if (cnt_q[i] != 4'h0) begin
        cnt_q[i] <= cnt_q[i] - 4'h1;
        if (cnt_q[i] == 4'h1) done_o[pt_q[i]] <= 1'b1;
      end
    end
  end
  assign dn_ready_o = {cnt_q[1] == 4'h0, cnt_q[0] == 4'h0};
endmodule
`default_nettype wire

/* bench/sfr_tb_top.sv */
// Self-checking testbench for the security filter and remap controller.
`timescale 1ns/100ps
`default_nettype none
module secure_filter_and_remap_tb_top;
  logic sys_clk_i = 1'b0, srst_i = 1'b1, avs_read_i = 1'b0, avs_write_i = 1'b0, cfg_ns_i = 1'b0;
  logic [3:0] avs_address_i = 4'h0, avs_byteenable_i = 4'hf, si_resp_o;
  logic [31:0] avs_writedata_i = 32'h0000_0000, si_addr_i = 32'h0000_0000, avs_readdata_o, rd;
  logic avs_waitrequest_o;
  logic [1:0] avs_response_o, si_valid_i = 2'h0, si_ns_i = 2'h0, si_lock_i = 2'h0;
  logic [1:0] si_dn_ready_i, si_ready_o, si_fwd_o, si_err_o;
  logic [5:0] si_tgt_o, pt_done_i, pt_sec_o;
  int n_errors = 0, comparisons = 0, nw;
  sfr_top DUT (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .cfg_ns_i(cfg_ns_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o),
    .si_valid_i(si_valid_i), .si_addr_i(si_addr_i), .si_ns_i(si_ns_i), .si_lock_i(si_lock_i),
    .si_dn_ready_i(si_dn_ready_i), .si_ready_o(si_ready_o), .si_fwd_o(si_fwd_o),
    .si_tgt_o(si_tgt_o), .si_resp_o(si_resp_o), .si_err_o(si_err_o), .pt_done_i(pt_done_i),
    .pt_sec_o(pt_sec_o));
  sfr_far FAR (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .fwd_i(si_fwd_o), .tgt_i(si_tgt_o),
    .dn_ready_o(si_dn_ready_i), .done_o(pt_done_i));
  always #20 sys_clk_i = ~sys_clk_i;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic ns,
                    input logic [1:0] er);
    @(posedge sys_clk_i);
    avs_read_i <= !wr;
    avs_write_i <= wr;
    avs_address_i <= a;
    avs_writedata_i <= d;
    cfg_ns_i <= ns;
    nw = 0;
    do begin
      @(posedge sys_clk_i);
      nw++;
    end while (avs_waitrequest_o);
    rd = avs_readdata_o;
    chk(avs_response_o, er);
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task automatic si(input int k, input logic [15:0] a, input logic ns, input logic [2:0] t,
                    input logic [1:0] r);
    @(posedge sys_clk_i);
    si_valid_i[k] <= 1'b1;
    si_addr_i[k*16 +: 16] <= a;
    si_ns_i[k] <= ns;
    do begin
      @(posedge sys_clk_i);
    end while (!si_ready_o[k]);
    si_valid_i[k] <= 1'b0;
    #1;
    chk({si_tgt_o[k*3 +: 3], si_resp_o[k*2 +: 2], si_fwd_o[k], si_err_o[k]},
        {t, r, r == 2'h0, r == 2'h3});
  endtask
  initial begin
    repeat (4) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    chk(pt_sec_o, 6'h3b);
    av(1'b0, 4'h8, 32'h0000_0000, 1'b0, 2'h0);
    chk(rd, 32'h0000_003b);
    av(1'b0, 4'h0, 32'h0000_0000, 1'b1, 2'h3);
    chk(rd, 32'h0000_0000);
    av(1'b1, 4'h0, 32'h0000_0001, 1'b1, 2'h3);
    av(1'b0, 4'hc, 32'h0000_0000, 1'b0, 2'h3);
    avs_byteenable_i <= 4'he;
    av(1'b1, 4'h0, 32'h0000_00ff, 1'b0, 2'h0);
    avs_byteenable_i <= 4'hf;
    av(1'b0, 4'h0, 32'h0000_0000, 1'b0, 2'h0);
    chk(rd, 32'h0000_0000);
    $display("test access done");
    si(0, 16'h0000, 1'b0, 3'h1, 2'h0);
    si(1, 16'h8000, 1'b0, 3'h7, 2'h3);
    av(1'b1, 4'h0, 32'h0000_0001, 1'b0, 2'h0);
    si(0, 16'h0000, 1'b0, 3'h0, 2'h0);
    si(1, 16'h0000, 1'b0, 3'h1, 2'h3);
    si(1, 16'h8000, 1'b0, 3'h6, 2'h3);
    av(1'b0, 4'h8, 32'h0000_0000, 1'b0, 2'h0);
    chk(rd, 32'h0000_013b);
    av(1'b1, 4'h0, 32'h0000_0006, 1'b0, 2'h0);
    si(0, 16'h0000, 1'b0, 3'h0, 2'h0);
    si_lock_i <= 2'h1;
    fork
      av(1'b1, 4'h0, 32'h0000_0004, 1'b0, 2'h0);
      begin
        si(0, 16'h0000, 1'b0, 3'h0, 2'h0);
        repeat (4) @(posedge sys_clk_i);
        chk(avs_waitrequest_o, 1'b1);
        si_lock_i <= 2'h0;
      end
    join
    si(0, 16'h0000, 1'b0, 3'h7, 2'h3);
    av(1'b1, 4'h0, 32'h0000_0002, 1'b0, 2'h0);
    si(0, 16'h2000, 1'b0, 3'h7, 2'h3);
    av(1'b1, 4'h0, 32'h0000_0000, 1'b0, 2'h0);
    si(0, 16'h2000, 1'b0, 3'h0, 2'h0);
    $display("test remap done");
    si(0, 16'h2000, 1'b1, 3'h0, 2'h3);
    si(0, 16'h3000, 1'b1, 3'h2, 2'h0);
    si(0, 16'h4000, 1'b1, 3'h3, 2'h3);
    si(0, 16'h2000, 1'b0, 3'h0, 2'h0);
    av(1'b1, 4'h4, 32'h0000_0000, 1'b0, 2'h0);
    chk(nw >= 10, 1'b1);
    chk(pt_sec_o, 6'h12);
    si(0, 16'h4000, 1'b1, 3'h3, 2'h0);
    si(0, 16'h5000, 1'b1, 3'h4, 2'h3);
    si(0, 16'h2000, 1'b1, 3'h0, 2'h0);
    si(0, 16'h1000, 1'b1, 3'h1, 2'h3);
    si(0, 16'h7000, 1'b1, 3'h6, 2'h3);
    av(1'b1, 4'h4, 32'h0000_003f, 1'b0, 2'h0);
    av(1'b0, 4'h8, 32'h0000_0000, 1'b0, 2'h0);
    chk(rd, 32'h0000_003b);
    $display("test security done");
    end_sim();
  end
  initial begin
    #400000;
    n_errors++;
    end_sim();
  end
endmodule
bind sfr_top sfr_asserts CHK (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .cfg_ns_i(cfg_ns_i), .avs_waitrequest_o(avs_waitrequest_o),
  .avs_response_o(avs_response_o), .avs_readdata_o(avs_readdata_o), .si_valid_i(si_valid_i),
  .si_dn_ready_i(si_dn_ready_i), .si_ready_o(si_ready_o), .si_fwd_o(si_fwd_o),
  .si_err_o(si_err_o), .si_resp_o(si_resp_o), .pt_sec_o(pt_sec_o));
`default_nettype wire
